// File: audio_cfg_pkg.sv
// constants for the audio clock, protection and serial input block
package audio_cfg_pkg;
  // host control port
  localparam logic [7:0] DEV_ADDR_SA0  = 8'h34;
  localparam logic [7:0] DEV_ADDR_SA1  = 8'h36;
  localparam logic [7:0] REG_CLK_PROT  = 8'h00;
  localparam logic [7:0] REG_SER_IN    = 8'h01;
  localparam logic [7:0] REG_STATUS    = 8'h2D;
  localparam logic [7:0] CLK_PROT_RST  = 8'h43;
  localparam logic [7:0] SER_IN_RST    = 8'h80;
  // field positions
  localparam int RATIO_LSB     = 0;
  localparam int INTERP_LSB    = 3;
  localparam int RECOV_BYP_BIT = 5;
  localparam int ADJ_BYP_BIT   = 6;
  localparam int FAULT_BYP_BIT = 7;
  localparam int FMT_LSB       = 0;
  localparam int ORDER_BIT     = 4;
  localparam int DLY_BIT       = 5;
  localparam int MAP1_BIT      = 6;
  localparam int MAP2_BIT      = 7;
  localparam int ST_WARN_BIT   = 0;
  localparam int ST_FAULT_BIT  = 1;
  localparam int ST_CUT_BIT    = 4;
  localparam int ST_UNSUP_BIT  = 5;
  // serial framing modes, low two bits of the format field
  localparam logic [1:0] FMT_I2S = 2'h0;
  localparam logic [1:0] FMT_LJ  = 2'h1;
  localparam logic [1:0] FMT_RJ  = 2'h2;
  // master clock ratio in multiples of fs, zero marks unsupported
  localparam logic [9:0] RATIO_BASE [8] = '{10'h300, 10'h200, 10'h180,
    10'h100, 10'h080, 10'h240, 10'h000, 10'h000};
  localparam logic [9:0] RATIO_HIGH [8] = '{10'h180, 10'h100, 10'h0C0,
    10'h080, 10'h040, 10'h000, 10'h000, 10'h000};
  localparam logic [10:0] INT_CLK_FS = 11'h400;
  // timing
  localparam int CLK_HZ         = 10_000_000;
  localparam int THERM_MS       = 400;
  localparam int THERM_CYC      = THERM_MS * (CLK_HZ / 1000);
  localparam int FAULT_UNIT_US  = 100;
  localparam int FAULT_UNIT_CYC = FAULT_UNIT_US * (CLK_HZ / 1_000_000);
endpackage : audio_cfg_pkg

// File: sample_fifo.sv
// synchronous sample fifo with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module sample_fifo
  import audio_cfg_pkg::*;
#(
  parameter int WIDTH = 48,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  // drain side
  output logic                  outValid,
  output logic      [WIDTH-1:0] outData,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two, at least 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_r;
  logic [AW-1:0]    rdPtr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;
  assign inReady  = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData  = mem[rdPtr_r];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) wrPtr_r <= wrPtr_r + 1'b1;
      if (pop) rdPtr_r <= rdPtr_r + 1'b1;
      if (push && !pop) count_r <= count_r + 1'b1;
      else if (pop && !push) count_r <= count_r - 1'b1;
    end
  end
endmodule : sample_fifo
`default_nettype wire

// File: serial_audio_rx.sv
// serial audio slave receiver running on the source's bit clock
`timescale 1ns/10ps
`default_nettype none
module serial_audio_rx
  import audio_cfg_pkg::*;
(
  // link clock and reset
  input  wire logic        bitClkIn,
  input  wire logic        rst_n,
  // link pins
  input  wire logic        wordClkIn,
  input  wire logic        serialAudioIn,
  // quasi-static settings from the core domain
  input  wire logic [3:0]  serialInFormat,
  input  wire logic        serialInBitOrder,
  input  wire logic        serialClkDelayEn,
  // frame out, right data stands until the next toggle, left data until the next left half ends
  output logic      [23:0] leftData_r,
  output logic      [23:0] rightData_r,
  output logic             frameTgl_r
);
  logic [5:0]  cfgS1_r;
  logic [5:0]  cfgS2_r;
  logic        wcN_r;
  logic        sdN_r;
  logic        wcPrev_r;
  logic [31:0] sr_r;
  logic [5:0]  cnt_r;
  logic        wc;
  logic        sd;
  logic [1:0]  mode;
  logic        leftEnded;
  logic [23:0] word;

  function automatic logic [23:0] pick(input logic [31:0] v,
      input logic [5:0] n, input logic [1:0] md, input logic [1:0] ws,
      input logic lsb);
    logic [5:0]  w;
    logic [5:0]  sh;
    logic [31:0] e;
    logic [31:0] r;
    w = (ws == 2'h0) ? 6'h18 : (ws == 2'h1) ? 6'h14 :
        (ws == 2'h2) ? 6'h12 : 6'h10;
    sh = (md == FMT_RJ) ? 6'h01 : (md == FMT_LJ) ? n + 6'h01 - w : n - w;
    e = (v >> sh) & ((32'h1 << w) - 32'h1);
    r = e;
    if (lsb) begin
      for (int i = 0; i < 32; i++) r[i] = e[31-i];
      r = r >> (6'h20 - w);
    end
    pick = 24'(r << (6'h18 - w));
  endfunction : pick

  // settings cross as a level; they are only changed between streams
  always_ff @(posedge bitClkIn or negedge rst_n) begin
    if (!rst_n) begin
      cfgS1_r <= '0;
      cfgS2_r <= '0;
    end else begin
      cfgS1_r <= {serialClkDelayEn, serialInBitOrder, serialInFormat};
      cfgS2_r <= cfgS1_r;
    end
  end
  // late sampling point on the falling edge for skewed masters
  always_ff @(negedge bitClkIn or negedge rst_n) begin
    if (!rst_n) begin
      wcN_r <= 1'b0;
      sdN_r <= 1'b0;
    end else begin
      wcN_r <= wordClkIn;
      sdN_r <= serialAudioIn;
    end
  end
  assign wc = cfgS2_r[DLY_BIT] ? wcN_r : wordClkIn;
  assign sd = cfgS2_r[DLY_BIT] ? sdN_r : serialAudioIn;
  assign mode = cfgS2_r[FMT_LSB +: 2];
  assign leftEnded = (wcPrev_r == (mode != FMT_I2S));
  assign word = pick({sr_r[30:0], sd}, cnt_r, mode, cfgS2_r[3:2],
                     cfgS2_r[ORDER_BIT]);

  // two channels framed by the word clock, we never drive the link
  always_ff @(posedge bitClkIn or negedge rst_n) begin
    if (!rst_n) begin
      wcPrev_r    <= 1'b0;
      sr_r        <= '0;
      cnt_r       <= '0;
      leftData_r  <= '0;
      rightData_r <= '0;
      frameTgl_r  <= 1'b0;
    end else begin
      wcPrev_r <= wc;
      sr_r     <= {sr_r[30:0], sd};
      if (wc != wcPrev_r) begin
        cnt_r <= 6'h01;
        if (leftEnded) begin
          leftData_r <= word;
        end else begin
          rightData_r <= word;
          frameTgl_r  <= ~frameTgl_r;
        end
      end else if (cnt_r != 6'h20) begin
        cnt_r <= cnt_r + 6'h01;
      end
    end
  end
endmodule : serial_audio_rx
`default_nettype wire

// File: audio_cfg_top.sv
// clock, protection and serial input configuration with host port
`timescale 1ns/10ps
`default_nettype none
module audio_cfg_top
  import audio_cfg_pkg::*;
#(
  parameter int THERM_CYCLES = THERM_CYC
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // host control port, open drain data
  input  wire logic        scl,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  input  wire logic        addrSel,
  // power stage
  input  wire logic        thermalWarningN,
  input  wire logic        faultN,
  input  wire logic [15:0] faultRecovTimeConst,
  output logic             triStateN,
  output logic             gainCutActive,
  // clock generator and interpolator control
  output logic      [10:0] pllNum,
  output logic      [9:0]  pllDen,
  output logic             ratioUnsupported,
  output logic             interpUp2,
  output logic             interpPass,
  output logic             interpDown2,
  // serial audio link
  input  wire logic        bitClkIn,
  input  wire logic        wordClkIn,
  input  wire logic        serialAudioIn,
  // processed channel pairs
  output logic             chanValid,
  input  wire logic        chanReady,
  output logic      [23:0] chan1Data,
  output logic      [23:0] chan2Data
);
  if (THERM_CYCLES < 2) begin : g_bad_therm
    $error("thermal threshold must be at least two cycles");
  end

  typedef enum logic [8:0] {
    I_IDLE = 9'h001, I_ADDR = 9'h002, I_ACKA = 9'h004,
    I_SUB  = 9'h008, I_ACKS = 9'h010, I_WDAT = 9'h020,
    I_ACKW = 9'h040, I_RDAT = 9'h080, I_RACK = 9'h100
  } host_state_t;
  typedef enum logic [2:0] {
    F_IDLE = 3'h1, F_LOW = 3'h2, F_HIGH = 3'h4
  } fault_state_t;

  logic [1:0]   sclS_r, sdaS_r, warnS_r, faultS_r, selS_r, tglS_r;
  logic         sclD_r, sdaD_r, tglD_r;
  host_state_t  hSt_r;
  logic [3:0]   bitCnt_r;
  logic [7:0]   rxSr_r, txSr_r, ptr_r, rdData;
  logic         rw_r, nack_r, wrStb;
  logic [7:0]   clkProtCfg_r, serInCfg_r;
  logic [31:0]  thermCnt_r;
  logic         gainCut_r, triStateN_r;
  fault_state_t fSt_r;
  logic [9:0]   unitCnt_r;
  logic [15:0]  holdCnt_r;
  logic [10:0]  pllNum_r;
  logic [9:0]   pllDen_r;
  logic         unsup_r, up2_r, pass_r, down2_r;
  logic [23:0]  left, right;
  logic         frameTgl, pend_r, fifoReady;
  logic [47:0]  pendData_r;
  logic         sclRise, sclFall, startC, stopC, sda;
  logic         warnAct, faultAct, unitTick;
  logic [15:0]  tcEff;
  logic [2:0]   clkRatioSel;
  logic [1:0]   interpRatioSel;
  logic         thermalAdjBypass, thermalRecovBypass, faultRecovBypass;
  logic         chan1InputMap, chan2InputMap;

  // host, warning, fault and address select pins and the frame toggle pass two flops first
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sclS_r   <= 2'h3;
      sdaS_r   <= 2'h3;
      warnS_r  <= 2'h3;
      faultS_r <= 2'h3;
      selS_r   <= 2'h0;
      tglS_r   <= 2'h0;
      sclD_r   <= 1'b1;
      sdaD_r   <= 1'b1;
      tglD_r   <= 1'b0;
    end else begin
      sclS_r   <= {sclS_r[0], scl};
      sdaS_r   <= {sdaS_r[0], sdaIn};
      warnS_r  <= {warnS_r[0], thermalWarningN};
      faultS_r <= {faultS_r[0], faultN};
      selS_r   <= {selS_r[0], addrSel};
      tglS_r   <= {tglS_r[0], frameTgl};
      sclD_r   <= sclS_r[1];
      sdaD_r   <= sdaS_r[1];
      tglD_r   <= tglS_r[1];
    end
  end
  assign sda     = sdaS_r[1];
  assign sclRise = sclS_r[1] & ~sclD_r;
  assign sclFall = ~sclS_r[1] & sclD_r;
  assign startC  = sclS_r[1] & sclD_r & sdaD_r & ~sda;
  assign stopC   = sclS_r[1] & sclD_r & ~sdaD_r & sda;
  assign wrStb   = (hSt_r == I_WDAT) & sclFall & (bitCnt_r == 4'h8);

  // host byte engine: address, register pointer, then data bytes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hSt_r    <= I_IDLE;
      bitCnt_r <= '0;
      rxSr_r   <= '0;
      txSr_r   <= '0;
      ptr_r    <= '0;
      rw_r     <= 1'b0;
      nack_r   <= 1'b0;
    end else begin
      if (sclRise) rxSr_r <= {rxSr_r[6:0], sda};
      if (startC) begin
        hSt_r    <= I_ADDR;
        bitCnt_r <= '0;
      end else if (stopC) begin
        hSt_r <= I_IDLE;
      end else begin
        unique case (hSt_r)
          I_IDLE: ;
          I_ADDR, I_SUB, I_WDAT: begin
            if (sclRise) begin
              bitCnt_r <= bitCnt_r + 4'h1;
            end else if (sclFall && bitCnt_r == 4'h8) begin
              bitCnt_r <= '0;
              if (hSt_r == I_SUB) begin
                ptr_r <= rxSr_r;
                hSt_r <= I_ACKS;
              end else if (hSt_r == I_WDAT) begin
                ptr_r <= ptr_r + 8'h01;
                hSt_r <= I_ACKW;
              end else if (rxSr_r[7:1] == (selS_r[1] ? DEV_ADDR_SA1[7:1]
                                        : DEV_ADDR_SA0[7:1])) begin
                rw_r  <= rxSr_r[0];
                hSt_r <= I_ACKA;
              end else begin
                hSt_r <= I_IDLE;
              end
            end
          end
          I_ACKA: begin
            if (sclFall) begin
              txSr_r <= rdData;
              hSt_r  <= rw_r ? I_RDAT : I_SUB;
            end
          end
          I_ACKS, I_ACKW: begin
            if (sclFall) hSt_r <= I_WDAT;
          end
          I_RDAT: begin
            if (sclRise) begin
              bitCnt_r <= bitCnt_r + 4'h1;
            end else if (sclFall) begin
              if (bitCnt_r == 4'h8) begin
                bitCnt_r <= '0;
                ptr_r    <= ptr_r + 8'h01;
                hSt_r    <= I_RACK;
              end else begin
                txSr_r <= {txSr_r[6:0], 1'b0};
              end
            end
          end
          I_RACK: begin
            if (sclRise) begin
              nack_r <= sda;
            end else if (sclFall) begin
              txSr_r <= rdData;
              hSt_r  <= nack_r ? I_IDLE : I_RDAT;
            end
          end
        endcase
      end
    end
  end
  // the slave only ever pulls the line low
  assign sdaOut = 1'b0;
  assign sdaOe  = (hSt_r == I_ACKA) | (hSt_r == I_ACKS) |
                  (hSt_r == I_ACKW) | ((hSt_r == I_RDAT) & ~txSr_r[7]);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clkProtCfg_r <= CLK_PROT_RST;
      serInCfg_r   <= SER_IN_RST;
    end else if (wrStb) begin
      if (ptr_r == REG_CLK_PROT) clkProtCfg_r <= rxSr_r;
      if (ptr_r == REG_SER_IN) serInCfg_r <= rxSr_r;
    end
  end
  always_comb begin
    rdData = 8'h00;
    if (ptr_r == REG_CLK_PROT) rdData = clkProtCfg_r;
    if (ptr_r == REG_SER_IN) rdData = serInCfg_r;
    if (ptr_r == REG_STATUS) begin
      rdData[ST_WARN_BIT]  = warnAct;
      rdData[ST_FAULT_BIT] = faultAct;
      rdData[ST_CUT_BIT]   = gainCut_r;
      rdData[ST_UNSUP_BIT] = unsup_r;
    end
  end
  assign clkRatioSel        = clkProtCfg_r[RATIO_LSB +: 3];
  assign interpRatioSel     = clkProtCfg_r[INTERP_LSB +: 2];
  assign thermalRecovBypass = clkProtCfg_r[RECOV_BYP_BIT];
  assign thermalAdjBypass   = clkProtCfg_r[ADJ_BYP_BIT];
  assign faultRecovBypass   = clkProtCfg_r[FAULT_BYP_BIT];
  assign chan1InputMap      = serInCfg_r[MAP1_BIT];
  assign chan2InputMap      = serInCfg_r[MAP2_BIT];

  // ratio lookup; the pll trusts the master clock to match it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pllNum_r <= INT_CLK_FS;
      pllDen_r <= RATIO_BASE[3];
      unsup_r  <= 1'b0;
      up2_r    <= 1'b1;
      pass_r   <= 1'b0;
      down2_r  <= 1'b0;
    end else begin
      pllDen_r <= (interpRatioSel == 2'h0) ? RATIO_BASE[clkRatioSel]
                : RATIO_HIGH[clkRatioSel];
      unsup_r  <= ((interpRatioSel == 2'h0) ? RATIO_BASE[clkRatioSel]
                : RATIO_HIGH[clkRatioSel]) == 10'h000;
      pllNum_r <= INT_CLK_FS >> (interpRatioSel[1] ? 2 :
                  interpRatioSel[0] ? 1 : 0);
      up2_r    <= (interpRatioSel == 2'h0);
      pass_r   <= (interpRatioSel == 2'h1);
      down2_r  <= interpRatioSel[1];
    end
  end

  // thermal warning timer and modulation limit cut
  assign warnAct = ~warnS_r[1];
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      thermCnt_r <= '0;
    end else if (!warnAct) begin
      thermCnt_r <= '0;
    end else if (thermCnt_r != 32'(THERM_CYCLES)) begin
      thermCnt_r <= thermCnt_r + 32'h1;
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gainCut_r <= 1'b0;
    end else if (thermalAdjBypass) begin
      gainCut_r <= 1'b0;
    end else if (warnAct && thermCnt_r == 32'(THERM_CYCLES - 1)) begin
      gainCut_r <= 1'b1;
    end else if (!warnAct && !thermalRecovBypass) begin
      gainCut_r <= 1'b0;
    end
  end

  // fault recovery: low for the constant in 0.1 ms units, then high
  assign faultAct = ~faultS_r[1];
  assign unitTick = (unitCnt_r == 10'(FAULT_UNIT_CYC - 1));
  assign tcEff    = (faultRecovTimeConst == 16'h0000) ? 16'h0001
                  : faultRecovTimeConst;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fSt_r       <= F_IDLE;
      triStateN_r <= 1'b1;
      unitCnt_r   <= '0;
      holdCnt_r   <= '0;
    end else begin
      unitCnt_r <= (fSt_r == F_IDLE || unitTick) ? 10'h000
                 : unitCnt_r + 10'h001;
      unique case (fSt_r)
        F_IDLE: begin
          holdCnt_r <= '0;
          if (faultAct && !faultRecovBypass) begin
            triStateN_r <= 1'b0;
            fSt_r       <= F_LOW;
          end
        end
        F_LOW: begin
          if (faultRecovBypass) begin
            triStateN_r <= 1'b1;
            fSt_r       <= F_IDLE;
          end else if (unitTick) begin
            holdCnt_r <= holdCnt_r + 16'h0001;
            if (holdCnt_r + 16'h0001 >= tcEff) begin
              triStateN_r <= 1'b1;
              holdCnt_r   <= '0;
              fSt_r       <= F_HIGH;
            end
          end
        end
        F_HIGH: begin
          if (unitTick) fSt_r <= F_IDLE;
        end
      endcase
    end
  end

  serial_audio_rx u_rx (
    .bitClkIn         (bitClkIn),
    .rst_n            (rst_n),
    .wordClkIn        (wordClkIn),
    .serialAudioIn    (serialAudioIn),
    .serialInFormat   (serInCfg_r[FMT_LSB +: 4]),
    .serialInBitOrder (serInCfg_r[ORDER_BIT]),
    .serialClkDelayEn (serInCfg_r[DLY_BIT]),
    .leftData_r       (left),
    .rightData_r      (right),
    .frameTgl_r       (frameTgl)
  );
  // link words are held a whole frame, so they are stable at the toggle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pend_r     <= 1'b0;
      pendData_r <= '0;
    end else if (tglS_r[1] ^ tglD_r) begin
      pend_r     <= 1'b1;
      pendData_r <= {chan1InputMap ? right : left,
                     chan2InputMap ? right : left};
    end else if (fifoReady) begin
      pend_r <= 1'b0;
    end
  end
  sample_fifo #(.WIDTH(48), .DEPTH(8)) u_fifo (
    .clk      (mclk),
    .rst_n    (rst_n),
    .inValid  (pend_r),
    .inData   (pendData_r),
    .inReady  (fifoReady),
    .outValid (chanValid),
    .outData  ({chan1Data, chan2Data}),
    .outReady (chanReady)
  );

  assign triStateN        = triStateN_r;
  assign gainCutActive    = gainCut_r;
  assign pllNum           = pllNum_r;
  assign pllDen           = pllDen_r;
  assign ratioUnsupported = unsup_r;
  assign interpUp2        = up2_r;
  assign interpPass       = pass_r;
  assign interpDown2      = down2_r;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence faultStart;
    fSt_r == F_IDLE && faultAct && !faultRecovBypass;
  endsequence
  AST_THERM_SET: assert property (warnAct && !thermalAdjBypass &&
    thermCnt_r == 32'(THERM_CYCLES - 1) |=> gainCut_r)
    else $error("thermal cut not applied at threshold");
  AST_THERM_RESTART: assert property (!warnAct && !gainCut_r
    |=> thermCnt_r == 32'h0 && !gainCut_r)
    else $error("short warning left timer or cut set");
  AST_THERM_CLR: assert property (gainCut_r && !thermalAdjBypass &&
    !thermalRecovBypass && !warnAct |=> !gainCut_r)
    else $error("thermal cut not removed");
  AST_THERM_KEEP: assert property (gainCut_r && !thermalAdjBypass &&
    thermalRecovBypass |=> gainCut_r)
    else $error("thermal cut dropped under recovery bypass");
  AST_FAULT_LOW: assert property (faultStart |=>
    !triStateN_r ##1 !triStateN_r)
    else $error("tri-state not pulled low on fault");
  AST_FAULT_BYP: assert property (faultRecovBypass &&
    fSt_r == F_IDLE |=> triStateN_r)
    else $error("recovery ran while bypassed");
  AST_RATIO_DEF: assert property (clkRatioSel == 3'h3 &&
    interpRatioSel == 2'h0 |=> pllDen_r == 10'h100 && !unsup_r)
    else $error("default ratio not 256 fs");
  AST_RATIO_UNSUP: assert property (clkRatioSel == 3'h5 &&
    interpRatioSel != 2'h0 |=> unsup_r && pllDen_r == 10'h000)
    else $error("high-rate code 101 not flagged");
  AST_PASS: assert property (interpRatioSel == 2'h1
    |=> pass_r && !up2_r && pllNum_r == 11'h200)
    else $error("pass-through setting not applied");
endmodule : audio_cfg_top
`default_nettype wire

// File: audio_source_model.sv
// serial audio source model: i2s framing, link clock runs only in frames
`timescale 1ns/10ps
`default_nettype none
module audio_source_model (
  // link pins
  output logic bitClk,
  output logic wordClk,
  output logic serData
);
  logic begun = 1'b0;
  initial begin
    bitClk  = 1'b0;
    wordClk = 1'b0;
    serData = 1'b0;
  end
  // this end makes both clocks, the device only listens
  task automatic frame(input logic [23:0] l, r, input logic lsb);
    logic [23:0] s;
    for (int c = 0; c < 2; c++) begin
      s = c ? r : l;
      for (int i = (c == 0 && begun); i < 32; i++) begin
        // pins move mid-low so both clock edges see settled levels
        #3 wordClk = c[0];
        // idle slots toggle so a stale level never looks valid
        if (i > 0 && i < 25)
          serData = lsb ? s[i-1] : s[24-i];
        else
          serData = ~serData;
        #3 bitClk = 1'b1;
        #6 bitClk = 1'b0;
      end
    end
    // first slot of the next left half closes the right half
    #3 wordClk = 1'b0;
    serData = ~serData;
    #3 bitClk = 1'b1;
    #6 bitClk = 1'b0;
    begun = 1'b1;
  endtask : frame
endmodule : audio_source_model
`default_nettype wire

// File: audio_cfg_top_tb.sv
// bench for clock, protection and serial input configuration
`timescale 1ns/10ps
`default_nettype none
module audio_cfg_top_tb;
  import audio_cfg_pkg::*;
  logic mclk = 1'b0, rst_n = 1'b0, scl = 1'b1, hSda = 1'b1;
  logic warnN = 1'b1, faultN = 1'b1, chanReady = 1'b0;
  logic sdaOut, sdaOe, triStateN, cut, unsup, up2, pass, dn2;
  logic chanValid, bitClk, wordClk, serData, a;
  logic [15:0] tc = 16'h0001;
  logic [10:0] pllNum;
  logic [9:0]  pllDen;
  logic [23:0] ch1, ch2;
  logic [7:0]  q;
  int n_errors = 0, total_checks = 0;
  wire logic sda = hSda & ~sdaOe;
  audio_cfg_top #(.THERM_CYCLES(50)) dut (
    .mclk(mclk), .rst_n(rst_n), .scl(scl), .sdaIn(sda),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSel(1'b0),
    .thermalWarningN(warnN), .faultN(faultN),
    .faultRecovTimeConst(tc), .triStateN(triStateN),
    .gainCutActive(cut), .pllNum(pllNum), .pllDen(pllDen),
    .ratioUnsupported(unsup), .interpUp2(up2), .interpPass(pass),
    .interpDown2(dn2), .bitClkIn(bitClk), .wordClkIn(wordClk),
    .serialAudioIn(serData), .chanValid(chanValid),
    .chanReady(chanReady), .chan1Data(ch1), .chan2Data(ch2));
  audio_source_model src (.bitClk(bitClk), .wordClk(wordClk),
    .serData(serData));
  always #50 mclk = ~mclk;
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic wrap_up();
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [23:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // host data bits move only while scl is low, 6 mclk per phase
  task automatic xbit(input logic b, output logic r);
    hSda = b;
    tick(6);
    scl = 1'b1;
    tick(3);
    r = sda;
    tick(3);
    scl = 1'b0;
  endtask : xbit
  task automatic xbyte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--)
      xbit(d[i], q[i]);
    xbit(1'b1, ack);
  endtask : xbyte
  task automatic start();
    hSda = 1'b1;
    tick(6);
    scl = 1'b1;
    tick(6);
    hSda = 1'b0;
    tick(6);
    scl = 1'b0;
  endtask : start
  task automatic stop();
    hSda = 1'b0;
    tick(6);
    scl = 1'b1;
    tick(6);
    hSda = 1'b1;
    tick(6);
  endtask : stop
  task automatic wr(input logic [7:0] p, d);
    start();
    xbyte(8'h34, a);
    xbyte(p, a);
    xbyte(d, a);
    stop();
  endtask : wr
  task automatic rd(input logic [7:0] p, e);
    start();
    xbyte(8'h34, a);
    xbyte(p, a);
    start();
    xbyte(8'h35, a);
    xbyte(8'hFF, a);
    stop();
    chk(q, e);
  endtask : rd
  task automatic pop(input logic [23:0] e1, e2);
    int k;
    for (k = 0; k < 100 && chanValid !== 1'b1; k++)
      tick(1);
    if (k == 100) begin
      n_errors++;
      wrap_up();
    end
    chk(ch1, e1);
    chk(ch2, e2);
    chanReady = 1'b1;
    tick(1);
    chanReady = 1'b0;
    tick(1);
  endtask : pop
  task automatic resetVals();
    chk({pllDen, up2, triStateN}, {10'h100, 2'b11});
    chk({sdaOut, sdaOe, cut, chanValid}, 4'h0);
    rd(8'h00, 8'h43);
    rd(8'h01, 8'h80);
    rd(8'h10, 8'h00);
    start();
    xbyte(8'h36, a);
    stop();
    chk(a, 1'b1);
  endtask : resetVals
  task automatic ratios();
    logic [9:0] b[6] = '{10'h300, 10'h200, 10'h180, 10'h100, 10'h080,
                         10'h240};
    logic [9:0] h[6] = '{10'h180, 10'h100, 10'h0C0, 10'h080, 10'h040,
                         10'h000};
    for (int ir = 0; ir < 3; ir++)
      for (int m = 0; m < 6; m++) begin
        wr(8'h00, 8'(ir * 8 + m));
        chk(pllDen, ir ? h[m] : b[m]);
        chk(unsup, 1'(ir != 0 && m == 5));
        chk(pllNum, 11'h400 >> ir);
        chk({up2, pass, dn2}, 3'b100 >> ir);
      end
    rd(8'h00, 8'h15);
  endtask : ratios
  task automatic thermal();
    wr(8'h00, 8'h03);
    warnN = 1'b0;
    tick(30);
    warnN = 1'b1;
    tick(10);
    chk(cut, 1'b0);
    warnN = 1'b0;
    tick(60);
    chk(cut, 1'b1);
    warnN = 1'b1;
    tick(10);
    chk(cut, 1'b0);
    wr(8'h00, 8'h23);
    warnN = 1'b0;
    tick(60);
    warnN = 1'b1;
    tick(10);
    chk(cut, 1'b1);
    wr(8'h00, 8'h03);
    chk(cut, 1'b0);
  endtask : thermal
  task automatic fault();
    faultN = 1'b0;
    for (int i = 0; i < 3; i++) begin
      tick(i ? 1000 : 10);
      chk(triStateN, 1'(i == 1));
    end
    faultN = 1'b1;
    // let the last high phase end so the bypass check means something
    tick(2100);
    wr(8'h00, 8'h83);
    faultN = 1'b0;
    tick(20);
    chk(triStateN, 1'b1);
    faultN = 1'b1;
  endtask : fault
  task automatic serial();
    // fifo takes all eight pairs while the consumer stalls
    for (int i = 0; i < 8; i++)
      src.frame(24'(i * 24'h111111), ~24'(i), 1'b0);
    for (int i = 0; i < 8; i++)
      pop(24'(i * 24'h111111), ~24'(i));
    chk(chanValid, 1'b0);
    wr(8'h01, 8'hD0);
    // settings cross on link edges, so one frame primes them
    src.frame(24'h0, 24'h0, 1'b1);
    src.frame(24'hA5C301, 24'h5A3C80, 1'b1);
    pop(24'h0, 24'h0);
    pop(24'h5A3C80, 24'h5A3C80);
    // late sampling lags one slot, so a third frame closes the second
    wr(8'h01, 8'hA0);
    src.frame(24'h0, 24'h0, 1'b0);
    src.frame(24'h3C5A96, 24'hC3A569, 1'b0);
    src.frame(24'h0, 24'h0, 1'b0);
    pop(24'h0, 24'h0);
    pop(24'h3C5A96, 24'hC3A569);
  endtask : serial
  initial begin
    tick(3);
    rst_n = 1'b1;
    tick(3);
    resetVals();
    ratios();
    thermal();
    fault();
    serial();
    wrap_up();
  end
endmodule : audio_cfg_top_tb
`default_nettype wire
